//--- bench/cmc_host.sv
// Purpose: processor model on the control port
// Assumes: each strobe phase held 5 cycles
// Notes: released data pins show the inverse of the last word
`timescale 1ns/100ps
module cmc_host (
   input wire logic clk,
   output logic [8:0] addr,
   output logic [15:0] data,
   output logic ce_n,
   output logic we_n,
   output logic oe_n,
   input wire logic [15:0] rdata,
   input wire logic drv_n
);
   logic legacy = 1'b1;
   initial {addr, data, ce_n, we_n, oe_n} = {9'h000, 16'h0000, 3'h6};
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(negedge clk);
      {addr, data, ce_n, we_n} = {a, d, 2'h0};
      repeat (5) @(negedge clk);
      {data, ce_n, we_n} = {~d, 2'h3};
      repeat (5) @(negedge clk);
   endtask
   task automatic rd(input logic [8:0] a, output logic [15:0] d);
      @(negedge clk);
      {addr, ce_n, oe_n} = {a, 2'h0};
      repeat (5) @(negedge clk);
      d = drv_n ? 16'hXXXX : rdata;
      {ce_n, oe_n} = {1'b1, ~legacy};
      repeat (5) @(negedge clk);
   endtask
endmodule

//--- bench/cmc_sva.sv
// Purpose: port checks for cmc_top
// Assumes: strobes held 4 or more cycles
// Notes: control pins reach the outputs 3 edges late, sample pins 1 edge late
`timescale 1ns/100ps
module cmc_sva #(parameter int SAMPLE_W = 12) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [8:0] ADDR,
   input wire logic [15:0] DATA_OUT,
   input wire logic DATA_OE_N,
   input wire logic CHIP_ENABLE_N,
   input wire logic WRITE_N,
   input wire logic OUTPUT_ENABLE_N,
   input wire logic [SAMPLE_W-1:0] P1_IN,
   input wire logic [SAMPLE_W-1:0] P1_IN_CONV,
   input wire logic POWER_DOWN,
   input wire logic LEGACY_MODE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   a_idle_no_drive: assert property ((CHIP_ENABLE_N | ~WRITE_N) [*4] |-> DATA_OE_N)
      else $error("bus driven while idle");
   a_read_drive: assert property ((~CHIP_ENABLE_N & WRITE_N & ~OUTPUT_ENABLE_N) [*4]
      |-> ~DATA_OE_N) else $error("bus not driven on read");
   a_read_steady: assert property ((~CHIP_ENABLE_N & WRITE_N) [*5] |-> $stable(DATA_OUT))
      else $error("read data moved");
   a_unmapped_zero: assert property ((~CHIP_ENABLE_N & WRITE_N & ADDR != 9'h00C) [*4]
      |-> DATA_OUT == 16'h0000) else $error("unmapped read not zero");
   a_legacy_exit: assert property (OUTPUT_ENABLE_N |-> ##3 !LEGACY_MODE)
      else $error("legacy mode kept");
   a_pd_reset: assert property ($past(RESET) |-> !POWER_DOWN && DATA_OE_N)
      else $error("powered down after reset");
   a_low_bits: assert property (!$past(RESET) |->
      P1_IN_CONV[SAMPLE_W-2:0] == $past(P1_IN[SAMPLE_W-2:0])) else $error("low bits");
   a_msb_follow: assert property (!$past(RESET) && $changed(P1_IN[SAMPLE_W-1])
      |=> $changed(P1_IN_CONV[SAMPLE_W-1])) else $error("msb lost");
endmodule

//--- bench/cmc_top_tb_top.sv
// Purpose: self-checking bench for cmc_top
// Assumes: loss count shortened to 8
// Notes: filter clock toggles every 50 ns
`timescale 1ns/100ps
module cmc_top_tb_top;
   logic clk = 1'b0, reset = 1'b1, fclk = 1'b0, frun = 1'b1;
   logic [8:0] a;
   logic [15:0] din, dout, rv;
   logic ce_n, we_n, oe_n, drv_n, pd, leg;
   logic [11:0] p1i = 12'hA5C, p2i = 12'h3C7, p1c, p2c;
   logic [23:0] p1o = 24'h8F1234, p2o = 24'h70ABCD, p1oc, p2oc;
   int err_count = 0, checked = 0, cyc = 0;
   always #12.5 clk = ~clk;
   always #50 if (frun) fclk = ~fclk;
   cmc_top #(.LOSS_CYC(8)) i_cmc_top (.CLK(clk), .RESET(reset), .ADDR(a), .DATA_IN(din),
      .DATA_OUT(dout), .DATA_OE_N(drv_n), .CHIP_ENABLE_N(ce_n), .WRITE_N(we_n),
      .OUTPUT_ENABLE_N(oe_n), .FILTER_CLK(fclk), .P1_IN(p1i), .P2_IN(p2i), .P1_OUT(p1o),
      .P2_OUT(p2o), .P1_IN_CONV(p1c), .P2_IN_CONV(p2c), .P1_OUT_CONV(p1oc),
      .P2_OUT_CONV(p2oc), .POWER_DOWN(pd), .LEGACY_MODE(leg));
   cmc_host i_cmc_host (.clk(clk), .addr(a), .data(din), .ce_n(ce_n), .we_n(we_n),
      .oe_n(oe_n), .rdata(dout), .drv_n(drv_n));
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
      checked++;
      if (e !== s) begin
         $display("mismatch %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic t_legacy;
      chk("legacy", 1, leg);
      i_cmc_host.rd(9'h00C, rv);
      chk("ctrl", 0, rv);
      chk("pd", 0, pd);
      i_cmc_host.legacy = 1'b0;
      i_cmc_host.oe_n = 1'b1;
      repeat (5) @(negedge clk);
      chk("legacy", 0, leg);
   endtask
   task automatic t_inv;
      for (int i = 0; i < 4; i++) begin
         i_cmc_host.wr(9'h00C, 16'h0001 << i);
         i_cmc_host.rd(9'h00C, rv);
         chk("ctrl", 16'h0001 << i, rv);
         chk("p1i", {i == 0, 11'h000} ^ p1i, p1c);
         chk("p2i", {i == 1, 11'h000} ^ p2i, p2c);
         chk("p1o", {i == 2, 23'h000000} ^ p1o, p1oc);
         chk("p2o", {i == 3, 23'h000000} ^ p2o, p2oc);
      end
      // Flip the sample sign bit so the follow check sees a real change
      p1i = p1i ^ 12'h800;
      repeat (2) @(negedge clk);
      chk("p1i", p1i, p1c);
   endtask
   task automatic t_force;
      i_cmc_host.wr(9'h00C, 16'hFFFF);
      i_cmc_host.rd(9'h00C, rv);
      chk("ctrl", 16'h003F, rv);
      chk("pd", 1, pd);
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      chk("pd", 0, pd);
      i_cmc_host.rd(9'h00C, rv);
      chk("ctrl", 0, rv);
   endtask
   task automatic t_loss;
      frun = 1'b0;
      repeat (20) @(negedge clk);
      chk("pd", 1, pd);
      frun = 1'b1;
      repeat (8) @(negedge clk);
      chk("pd", 0, pd);
      i_cmc_host.wr(9'h00C, 16'h0010);
      frun = 1'b0;
      repeat (20) @(negedge clk);
      chk("pd", 0, pd);
      frun = 1'b1;
      i_cmc_host.wr(9'h005, 16'hFFFF);
      i_cmc_host.rd(9'h005, rv);
      chk("unmapped", 0, rv);
      i_cmc_host.rd(9'h00C, rv);
      chk("ctrl", 16'h0010, rv);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_count++;
         wrap_up;
      end
   end
   initial begin
      repeat (8) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      t_legacy;
      t_inv;
      t_force;
      t_loss;
      wrap_up;
   end
endmodule
bind cmc_top cmc_sva #(.SAMPLE_W(SAMPLE_W)) i_cmc_sva (.CLK(CLK), .RESET(RESET),
   .ADDR(ADDR), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .CHIP_ENABLE_N(CHIP_ENABLE_N),
   .WRITE_N(WRITE_N), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .P1_IN(P1_IN),
   .P1_IN_CONV(P1_IN_CONV), .POWER_DOWN(POWER_DOWN), .LEGACY_MODE(LEGACY_MODE));

//--- logic/cmc_pkg.sv
// Purpose: Shared constants and carriers for the compatibility mode control block
// Assumes: Sixteen-bit control port with nine address lines
// Notes: Bit positions inside the enhancement register are fixed here
package cmc_pkg;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 16;
   localparam logic [8:0] ENH_CTRL_OFFSET = 9'h00C;
   localparam logic [15:0] ENH_CTRL_RESET = 16'h0000;
   localparam int BIT_INV_P1_IN = 0;
   localparam int BIT_INV_P2_IN = 1;
   localparam int BIT_INV_P1_OUT = 2;
   localparam int BIT_INV_P2_OUT = 3;
   localparam int BIT_LOSS_DIS = 4;
   localparam int BIT_FORCE_PD = 5;
   localparam logic [15:0] ENH_CTRL_MASK = 16'h003F;
   // Input clock must toggle within this many nanoseconds
   localparam int LOSS_TIME_NS = 1000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int LOSS_CYCLES = LOSS_TIME_NS / CLK_PERIOD_NS;
   localparam logic [1:0] BUS_IDLE = 2'h0;

   typedef struct packed {
      logic inv_p1_in;
      logic inv_p2_in;
      logic inv_p1_out;
      logic inv_p2_out;
   } cmc_inv_t;

   typedef struct packed {
      logic [8:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } cmc_acc_t;
endpackage

//--- logic/cmc_sync.sv
// Purpose: Two flip-flop synchroniser for pin levels
// Assumes: Input is asynchronous to CLK
// Notes: First stage feeds only the second
`timescale 1ns/100ps
module cmc_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s1_nxt;
   logic [W-1:0] s2_r;
   logic [W-1:0] s2_nxt;

   always_comb begin
      s1_nxt = din;
      s2_nxt = s1_r;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
      end
   end

   assign dout = s2_r;
endmodule

//--- logic/cmc_top.sv
// Purpose: Enhancement control register, sign inversion, clock loss power-down, port mode
// Assumes: Control port pins are asynchronous and pass a two-stage synchroniser
// Notes: Only the enhancement register lives here; other addresses read back zero
//
// Behaviour
// - Four enhancement bits invert the MSB of path one and two inputs and outputs.
// - All four inversion bits clear at reset, giving two's complement by default.
// - A stopped input clock forces the static power-down state.
// - Power-down from clock loss ends once the input clock toggles again.
// - One bit disables clock-loss detection, another forces power-down outright.
// - Loss-disable and force-power-down bits clear at reset.
// - Output-enable held low selects legacy mode: write pin is direction, enable is strobe.
// - Enhancement register sits at offset 12 and resets to the compatible state.
// - Data is captured while write and chip enable are low, held when either rises.
// - Data bus is driven only with enable and output-enable low and write high.
`timescale 1ns/100ps
module cmc_top #(
   parameter int SAMPLE_W = 12,
   parameter int OUT_W = 24,
   parameter int LOSS_CYC = cmc_pkg::LOSS_CYCLES
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [8:0] ADDR,
   input wire logic [15:0] DATA_IN,
   output logic [15:0] DATA_OUT,
   output logic DATA_OE_N,
   input wire logic CHIP_ENABLE_N,
   input wire logic WRITE_N,
   input wire logic OUTPUT_ENABLE_N,
   input wire logic FILTER_CLK,
   input wire logic [SAMPLE_W-1:0] P1_IN,
   input wire logic [SAMPLE_W-1:0] P2_IN,
   input wire logic [OUT_W-1:0] P1_OUT,
   input wire logic [OUT_W-1:0] P2_OUT,
   output logic [SAMPLE_W-1:0] P1_IN_CONV,
   output logic [SAMPLE_W-1:0] P2_IN_CONV,
   output logic [OUT_W-1:0] P1_OUT_CONV,
   output logic [OUT_W-1:0] P2_OUT_CONV,
   output logic POWER_DOWN,
   output logic LEGACY_MODE
);
   localparam int CNT_W = $clog2(LOSS_CYC + 1);
   localparam int PIN_W = 9 + 16 + 4;

   logic [PIN_W-1:0] pins_s;
   logic [8:0] addr_s;
   logic [15:0] wdata_s;
   logic ce_n_s;
   logic we_n_s;
   logic oe_n_s;
   logic fclk_s;

   cmc_sync #(.W(PIN_W)) u_sync (
      .clk(CLK),
      .reset(RESET),
      .din({ADDR, DATA_IN, CHIP_ENABLE_N, WRITE_N, OUTPUT_ENABLE_N, FILTER_CLK}),
      .dout(pins_s)
   );
   assign {addr_s, wdata_s, ce_n_s, we_n_s, oe_n_s, fclk_s} = pins_s;

   logic [15:0] ctrl_r;
   logic [15:0] ctrl_nxt;
   logic [15:0] dout_r;
   logic [15:0] dout_nxt;
   logic oe_n_r;
   logic oe_n_nxt;
   logic legacy_r;
   logic legacy_nxt;
   logic oe_seen_hi_r;
   logic oe_seen_hi_nxt;
   logic fclk_d_r;
   logic [CNT_W-1:0] idle_cnt_r;
   logic [CNT_W-1:0] idle_cnt_nxt;
   logic lost_r;
   logic lost_nxt;
   logic pd_r;
   logic pd_nxt;
   cmc_pkg::cmc_acc_t acc;
   cmc_pkg::cmc_inv_t inv;
   logic [SAMPLE_W-1:0] p1i_nxt;
   logic [SAMPLE_W-1:0] p2i_nxt;
   logic [OUT_W-1:0] p1o_nxt;
   logic [OUT_W-1:0] p2o_nxt;

   // Control port decode for both strobe styles
   always_comb begin
      acc.addr = addr_s;
      acc.wdata = wdata_s;
      // Legacy: write pin is the direction line, enable is the strobe
      if (legacy_r) begin
         acc.wr = !ce_n_s && !we_n_s;
         acc.rd = !ce_n_s && we_n_s;
      end else begin
         acc.wr = !ce_n_s && !we_n_s;
         acc.rd = !ce_n_s && !oe_n_s && we_n_s;
      end
   end

   // Register file and read path
   always_comb begin
      ctrl_nxt = ctrl_r;
      // Level capture: last value seen while both strobes are low is held
      if (acc.wr && acc.addr == cmc_pkg::ENH_CTRL_OFFSET) begin
         ctrl_nxt = acc.wdata & cmc_pkg::ENH_CTRL_MASK;
      end
      dout_nxt = 16'h0000;
      if (acc.rd && acc.addr == cmc_pkg::ENH_CTRL_OFFSET) begin
         dout_nxt = ctrl_r;
      end
      oe_n_nxt = !acc.rd;
      // Legacy mode latches off once output-enable is ever seen high
      oe_seen_hi_nxt = oe_seen_hi_r | oe_n_s;
      legacy_nxt = !(oe_seen_hi_r | oe_n_s);
   end

   // Clock-loss watchdog on the synchronised filter clock
   always_comb begin
      idle_cnt_nxt = idle_cnt_r;
      lost_nxt = lost_r;
      if (fclk_s != fclk_d_r) begin
         idle_cnt_nxt = '0;
         lost_nxt = 1'b0;
      end else if (idle_cnt_r == CNT_W'(LOSS_CYC)) begin
         lost_nxt = 1'b1;
      end else begin
         idle_cnt_nxt = idle_cnt_r + CNT_W'(1);
      end
      pd_nxt = ctrl_r[cmc_pkg::BIT_FORCE_PD]
         | (lost_r & !ctrl_r[cmc_pkg::BIT_LOSS_DIS]);
   end

   // Sign-bit inversion of sample words
   always_comb begin
      inv.inv_p1_in = ctrl_r[cmc_pkg::BIT_INV_P1_IN];
      inv.inv_p2_in = ctrl_r[cmc_pkg::BIT_INV_P2_IN];
      inv.inv_p1_out = ctrl_r[cmc_pkg::BIT_INV_P1_OUT];
      inv.inv_p2_out = ctrl_r[cmc_pkg::BIT_INV_P2_OUT];
      p1i_nxt = P1_IN ^ {inv.inv_p1_in, {(SAMPLE_W-1){1'b0}}};
      p2i_nxt = P2_IN ^ {inv.inv_p2_in, {(SAMPLE_W-1){1'b0}}};
      p1o_nxt = P1_OUT ^ {inv.inv_p1_out, {(OUT_W-1){1'b0}}};
      p2o_nxt = P2_OUT ^ {inv.inv_p2_out, {(OUT_W-1){1'b0}}};
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctrl_r <= cmc_pkg::ENH_CTRL_RESET;
         dout_r <= 16'h0000;
         oe_n_r <= 1'b1;
         legacy_r <= 1'b0;
         oe_seen_hi_r <= 1'b0;
         fclk_d_r <= 1'b0;
         idle_cnt_r <= '0;
         lost_r <= 1'b0;
         pd_r <= 1'b0;
         P1_IN_CONV <= '0;
         P2_IN_CONV <= '0;
         P1_OUT_CONV <= '0;
         P2_OUT_CONV <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         dout_r <= dout_nxt;
         oe_n_r <= oe_n_nxt;
         legacy_r <= legacy_nxt;
         oe_seen_hi_r <= oe_seen_hi_nxt;
         fclk_d_r <= fclk_s;
         idle_cnt_r <= idle_cnt_nxt;
         lost_r <= lost_nxt;
         pd_r <= pd_nxt;
         P1_IN_CONV <= p1i_nxt;
         P2_IN_CONV <= p2i_nxt;
         P1_OUT_CONV <= p1o_nxt;
         P2_OUT_CONV <= p2o_nxt;
      end
   end

   assign DATA_OUT = dout_r;
   assign DATA_OE_N = oe_n_r;
   assign POWER_DOWN = pd_r;
   assign LEGACY_MODE = legacy_r;
endmodule
